// ### irq_ctrl_pkg.sv
// Purpose: shared constants for the vectored interrupt controller register interface
// Assumes: 32-bit word registers, byte addresses within a 4-Kbyte window
// Notes: offsets are byte offsets from the window base
package irq_ctrl_pkg;
	localparam logic [31:0] WINDOW_BASE = 32'hffff_f000;
	localparam int WINDOW_BITS = 12;
	localparam int NUM_SOURCES = 32;
	localparam int LEVEL_BITS = 3;
	localparam int SRC_BITS = 5;
	localparam logic [11:0] OFF_MODE_FIRST = 12'h000;
	localparam logic [11:0] OFF_MODE_LAST = 12'h07c;
	localparam logic [11:0] OFF_HANDLER_FIRST = 12'h080;
	localparam logic [11:0] OFF_HANDLER_LAST = 12'h0fc;
	localparam logic [11:0] OFF_CUR_HANDLER = 12'h100;
	localparam logic [11:0] OFF_FAST_HANDLER = 12'h104;
	localparam logic [11:0] OFF_CUR_SOURCE = 12'h108;
	localparam logic [11:0] OFF_PENDING = 12'h10c;
	localparam logic [11:0] OFF_ENABLED = 12'h110;
	localparam logic [11:0] OFF_CORE_LINE = 12'h114;
	localparam logic [11:0] OFF_ENABLE_CMD = 12'h120;
	localparam logic [11:0] OFF_DISABLE_CMD = 12'h124;
	localparam logic [11:0] OFF_CLEAR_CMD = 12'h128;
	localparam logic [11:0] OFF_SET_CMD = 12'h12c;
	localparam logic [11:0] OFF_EOS_CMD = 12'h130;
	localparam logic [11:0] OFF_SPURIOUS = 12'h134;
	localparam logic [11:0] OFF_DEBUG = 12'h138;
	localparam logic [11:0] OFF_FAST_EN = 12'h140;
	localparam logic [11:0] OFF_FAST_DIS = 12'h144;
	localparam logic [11:0] OFF_FAST_STATE = 12'h148;
	localparam logic [11:0] OFF_INT_STATUS = 12'h150;
	localparam logic [11:0] OFF_INT_MASK = 12'h154;
	localparam int LEVEL_LSB = 0;
	localparam int TRIG_EDGE_BIT = 5;
	localparam int TRIG_MSB = 6;
	localparam int DBG_PROTECT_BIT = 0;
	localparam int DBG_GMASK_BIT = 1;
	localparam int EXT_SOURCE = 1;
	localparam int FAST_SOURCE = 0;
	localparam int STACK_DEPTH = 8;
	localparam int EV_IRQ = 0;
	localparam int EV_FIQ = 1;
	localparam int EV_SPURIOUS = 2;
	localparam int EV_BITS = 3;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

// ### handler_mem.sv
// Purpose: per-source handler address store with registered read
// Assumes: one write port, one read port
// Notes: read data appear one cycle after the address
`timescale 1ns/1ps
module handler_mem #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : gen_word
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					mem_q[g] <= '0;
				end else if (wr_en && wr_addr == AW'(g)) begin
					mem_q[g] <= wr_data;
				end
			end
		end
	endgenerate
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem_q[rd_addr];
		end
	end
endmodule

// ### vectored_irq_controller.sv
// Purpose: register interface of an eight-level vectored interrupt controller, 32 sources
// Assumes: plain register port, byte address, read data one cycle after the read strobe
// Notes: source 0 is the fast source, source 1 the external pin
// Behaviour
// [R01] decode a 4-Kbyte window at base 0xffff_f000
// [R02] 32 mode registers 0x00-0x7c and 32 handler registers 0x80-0xfc, reset zero
// [R03] read-only status registers at 0x100-0x114, reset zero except the external source pending bit
// [R04] external source pending mirrors its pin at reset; others start cleared
// [R05] command registers 0x120-0x130 write-only; spurious and debug registers 0x134, 0x138
// [R06] fast redirect enable/disable write-only 0x140/0x144, state read-only at 0x148
// [R07] mode low three bits give urgency, 0 least, 7 most urgent
// [R08] urgency of source 0 is ignored
// [R09] trigger type bit 5 picks level (0) or edge (1)
// [R10] handler registers keep and return any 32-bit value
// [R11] current-vector read returns handler of the current source, chosen at read
// [R12] with nothing current the current-vector read returns the spurious handler
// [R13] command bit one acts on that source, zero leaves it alone; the clear command here clears edge-triggered sources only
// [R14] any write to end-of-service ends the current treatment
// [R15] current-source register returns the serviced source number
// [R16] protect mode: stacking and acknowledge only on current-vector write
// [R17] reserved and write-only reads give zero; writes there do nothing
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module vectored_irq_controller #(
	parameter int NSRC = 32
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [NSRC-1:0] src_in,
	output logic irq_line,
	output logic fiq_line,
	output logic int_out
);
	localparam int SB = irq_ctrl_pkg::SRC_BITS;
	localparam int LB = irq_ctrl_pkg::LEVEL_BITS;
	localparam int SD = irq_ctrl_pkg::STACK_DEPTH;
	localparam int EB = irq_ctrl_pkg::EV_BITS;

	typedef struct packed {
		logic [NSRC-1:0][6:0] mode;
		logic [NSRC-1:0] pend;
		logic [NSRC-1:0] en;
		logic [NSRC-1:0] fast;
		logic [NSRC-1:0] src_prev;
		logic [31:0] spurious;
		logic [1:0] dbg;
		logic [SD-1:0][LB-1:0] stk_lvl;
		logic [SD-1:0][SB-1:0] stk_src;
		logic [3:0] depth;
		logic [SB-1:0] cur_src;
		logic [SB-1:0] held_src;
		logic held_valid;
		logic rd_vec;
		logic rd_vec_spur;
		logic rd_fast;
		logic rd_fast_spur;
		logic rd_hand;
		logic [31:0] rd_word;
		logic irq;
		logic fiq;
		logic [EB-1:0] ev_stat;
		logic [EB-1:0] ev_mask;
		logic intr;
		logic init;
	} state_t;

	state_t q, d;

	logic in_win;
	logic hand_hit;
	logic [11:0] off;
	logic [NSRC-1:0] active;
	logic [NSRC-1:0] cand;
	logic [SB-1:0] best_src;
	logic [LB-1:0] best_lvl;
	logic best_ok;
	logic [LB-1:0] cur_lvl;
	logic ack;
	logic mem_we;
	logic [SB-1:0] mem_ra;
	logic [31:0] mem_rd;
	logic irq_req;
	logic fiq_req;
	logic [EB-1:0] ev;

	assign in_win = (addr[31:irq_ctrl_pkg::WINDOW_BITS] == irq_ctrl_pkg::WINDOW_BASE[31:irq_ctrl_pkg::WINDOW_BITS]); // R01
	assign off = addr[irq_ctrl_pkg::WINDOW_BITS-1:0];
	// aligned access to a handler word
	assign hand_hit = in_win && off >= irq_ctrl_pkg::OFF_HANDLER_FIRST
		&& off <= irq_ctrl_pkg::OFF_HANDLER_LAST && off[1:0] == 2'h0; // R02
	assign mem_we = wr && hand_hit; // R10
	assign cur_lvl = (q.depth == 4'h0) ? '0 : q.stk_lvl[q.depth[2:0] - 3'h1];

	// best candidate above current level
	always_comb begin
		best_ok = 1'b0;
		best_src = '0;
		best_lvl = '0;
		for (int i = 1; i < NSRC; i++) begin
			cand[i] = q.pend[i] && q.en[i] && !q.fast[i];
			if (cand[i] && (!best_ok || q.mode[i][LB-1:0] > best_lvl)) begin // R07
				best_ok = 1'b1;
				best_src = SB'(i);
				best_lvl = q.mode[i][LB-1:0];
			end
		end
		cand[0] = 1'b0; // R08
		if (q.depth != 4'h0 && best_lvl <= cur_lvl) begin
			best_ok = 1'b0;
		end
	end

	assign irq_req = best_ok && !q.dbg[irq_ctrl_pkg::DBG_GMASK_BIT];
	assign fiq_req = ((q.pend[0] && q.en[0]) || |(q.pend & q.en & q.fast))
		&& !q.dbg[irq_ctrl_pkg::DBG_GMASK_BIT];

	// memory read index: current vector chosen at the read, fast always source 0
	always_comb begin
		mem_ra = best_ok ? best_src : q.cur_src; // R11
		if (rd && hand_hit) begin
			mem_ra = off[SB+1:2]; // R02
		end
		if (rd && off == irq_ctrl_pkg::OFF_FAST_HANDLER) begin
			mem_ra = SB'(irq_ctrl_pkg::FAST_SOURCE);
		end
		if (rd && off == irq_ctrl_pkg::OFF_CUR_HANDLER && q.dbg[irq_ctrl_pkg::DBG_PROTECT_BIT]
			&& q.held_valid) begin
			mem_ra = q.held_src;
		end
	end

	handler_mem #(.WIDTH(32), .DEPTH(NSRC), .AW(SB)) u_mem (
		.clk(clk),
		.nrst(nrst),
		.wr_en(mem_we),
		.wr_addr(addr[SB+1:2]),
		.wr_data(wdata),
		.rd_addr(mem_ra),
		.rd_data(mem_rd)
	);

	always_comb begin
		d = q;
		ack = 1'b0;
		ev = '0;
		d.init = 1'b0;
		d.src_prev = src_in;
		d.rd_vec = 1'b0;
		d.rd_fast = 1'b0;
		d.rd_hand = 1'b0;
		d.rd_word = '0; // R17
		// input sampling per source
		for (int i = 0; i < NSRC; i++) begin
			if (q.mode[i][irq_ctrl_pkg::TRIG_EDGE_BIT]) begin // R09
				if (src_in[i] && !q.src_prev[i]) begin
					d.pend[i] = 1'b1;
				end
			end else begin
				d.pend[i] = src_in[i];
			end
		end
		if (wr && in_win) begin
			if (off <= irq_ctrl_pkg::OFF_MODE_LAST && off[1:0] == 2'h0) begin
				d.mode[off[SB+1:2]] = wdata[irq_ctrl_pkg::TRIG_MSB:irq_ctrl_pkg::LEVEL_LSB]; // R02
			end
			case (off)
				irq_ctrl_pkg::OFF_ENABLE_CMD: d.en = q.en | wdata[NSRC-1:0]; // R13
				irq_ctrl_pkg::OFF_DISABLE_CMD: d.en = q.en & ~wdata[NSRC-1:0]; // R13
				irq_ctrl_pkg::OFF_SET_CMD: d.pend = d.pend | wdata[NSRC-1:0]; // R13
				irq_ctrl_pkg::OFF_CLEAR_CMD: begin
					for (int i = 0; i < NSRC; i++) begin
						if (wdata[i] && q.mode[i][irq_ctrl_pkg::TRIG_EDGE_BIT]
							&& !(src_in[i] && !q.src_prev[i])) begin // R13
							d.pend[i] = 1'b0;
						end
					end
				end
				irq_ctrl_pkg::OFF_SPURIOUS: d.spurious = wdata; // R05
				irq_ctrl_pkg::OFF_DEBUG: d.dbg = wdata[1:0]; // R05
				irq_ctrl_pkg::OFF_FAST_EN: d.fast = q.fast | wdata[NSRC-1:0]; // R06
				irq_ctrl_pkg::OFF_FAST_DIS: d.fast = q.fast & ~wdata[NSRC-1:0]; // R06
				irq_ctrl_pkg::OFF_INT_STATUS: d.ev_stat = q.ev_stat & ~wdata[EB-1:0];
				irq_ctrl_pkg::OFF_INT_MASK: d.ev_mask = wdata[EB-1:0];
				irq_ctrl_pkg::OFF_EOS_CMD: begin
					if (q.depth != 4'h0) begin // R14
						d.depth = q.depth - 4'h1;
						d.cur_src = (q.depth > 4'h1) ? q.stk_src[q.depth[2:0] - 3'h2] : '0;
					end
				end
				irq_ctrl_pkg::OFF_CUR_HANDLER: begin
					if (q.dbg[irq_ctrl_pkg::DBG_PROTECT_BIT] && q.held_valid) begin // R16
						ack = 1'b1;
						d.held_valid = 1'b0;
					end
				end
				default: ;
			endcase
		end
		if (rd && in_win) begin
			case (off)
				irq_ctrl_pkg::OFF_CUR_HANDLER: begin
					d.rd_vec = 1'b1;
					d.rd_vec_spur = !best_ok && !(q.dbg[irq_ctrl_pkg::DBG_PROTECT_BIT] && q.held_valid); // R12
					if (!best_ok && !q.held_valid) begin
						ev[irq_ctrl_pkg::EV_SPURIOUS] = 1'b1;
					end
					if (best_ok && !q.dbg[irq_ctrl_pkg::DBG_PROTECT_BIT]) begin
						ack = 1'b1; // R16
					end else if (best_ok && !q.held_valid) begin
						d.held_valid = 1'b1;
						d.held_src = best_src;
					end
				end
				irq_ctrl_pkg::OFF_FAST_HANDLER: begin
					d.rd_fast = 1'b1;
					d.rd_fast_spur = !fiq_req;
					if (q.mode[0][irq_ctrl_pkg::TRIG_EDGE_BIT] && !q.fast[0]) begin
						d.pend[0] = src_in[0] && !q.src_prev[0];
					end
				end
				irq_ctrl_pkg::OFF_CUR_SOURCE: d.rd_word = {{(32-SB){1'b0}}, q.cur_src}; // R15
				irq_ctrl_pkg::OFF_PENDING: d.rd_word = q.pend; // R03
				irq_ctrl_pkg::OFF_ENABLED: d.rd_word = q.en; // R03
				irq_ctrl_pkg::OFF_CORE_LINE: d.rd_word = {30'h0, q.irq, q.fiq}; // R03
				irq_ctrl_pkg::OFF_SPURIOUS: d.rd_word = q.spurious;
				irq_ctrl_pkg::OFF_DEBUG: d.rd_word = {30'h0, q.dbg};
				irq_ctrl_pkg::OFF_FAST_STATE: d.rd_word = q.fast; // R06
				irq_ctrl_pkg::OFF_INT_STATUS: d.rd_word = {29'h0, q.ev_stat};
				irq_ctrl_pkg::OFF_INT_MASK: d.rd_word = {29'h0, q.ev_mask};
				default: begin
					if (off <= irq_ctrl_pkg::OFF_MODE_LAST && off[1:0] == 2'h0) begin
						d.rd_word = {25'h0, q.mode[off[SB+1:2]]};
					end else if (hand_hit) begin
						d.rd_hand = 1'b1; // R10
					end
				end
			endcase
		end
		// acknowledge: push level and source, clear edge source
		if (ack) begin
			if (q.dbg[irq_ctrl_pkg::DBG_PROTECT_BIT]) begin
				d.stk_lvl[q.depth[2:0]] = q.mode[q.held_src][LB-1:0];
				d.stk_src[q.depth[2:0]] = q.held_src;
				d.cur_src = q.held_src; // R16
				if (q.mode[q.held_src][irq_ctrl_pkg::TRIG_EDGE_BIT]) begin
					d.pend[q.held_src] = 1'b0;
				end
			end else begin
				d.stk_lvl[q.depth[2:0]] = best_lvl;
				d.stk_src[q.depth[2:0]] = best_src;
				d.cur_src = best_src;
				if (q.mode[best_src][irq_ctrl_pkg::TRIG_EDGE_BIT]) begin
					d.pend[best_src] = 1'b0;
				end
			end
			if (q.depth < 4'(SD)) begin
				d.depth = q.depth + 4'h1;
			end
		end
		if (q.init) begin
			d.pend = '0; // R04
			d.pend[irq_ctrl_pkg::EXT_SOURCE] = src_in[irq_ctrl_pkg::EXT_SOURCE]; // R04
		end
		d.irq = irq_req;
		d.fiq = fiq_req;
		ev[irq_ctrl_pkg::EV_IRQ] = irq_req && !q.irq;
		ev[irq_ctrl_pkg::EV_FIQ] = fiq_req && !q.fiq;
		d.ev_stat = d.ev_stat | ev;
		d.intr = |(d.ev_stat & d.ev_mask);
	end

	// read data mux: vectors come from the memory register
	always_comb begin
		if (q.rd_vec) begin
			rdata = q.rd_vec_spur ? q.spurious : mem_rd; // R12
		end else if (q.rd_fast) begin
			rdata = q.rd_fast_spur ? q.spurious : mem_rd;
		end else if (q.rd_hand) begin
			rdata = mem_rd; // R10
		end else begin
			rdata = q.rd_word;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.init <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign irq_line = q.irq;
	assign fiq_line = q.fiq;
	assign int_out = q.intr;
endmodule

// ### irq_ctrl_checker_asserts.sv
// Purpose: port-level checks of the register port
// Assumes: one clock, async active-low reset
// Notes: shadow state mirrors enable, disable, fast redirect and spurious writes
`timescale 1ns/1ps
module irq_ctrl_checker (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata
);
	typedef struct packed {
		logic [31:0] en;
		logic [31:0] ff;
		logic [31:0] spu;
	} shadow_t;
	shadow_t s_q;
	shadow_t s_d;
	logic inwin;
	logic [11:0] off;
	assign inwin = addr[31:12] == 20'hfffff;
	assign off = addr[11:0];
	always_comb begin
		s_d = s_q;
		if (wr && inwin) begin
			case (off)
				12'h120: s_d.en = s_q.en | wdata;
				12'h124: s_d.en = s_q.en & ~wdata;
				12'h140: s_d.ff = s_q.ff | wdata;
				12'h144: s_d.ff = s_q.ff & ~wdata;
				12'h134: s_d.spu = wdata;
				default: ;
			endcase
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_idle; !rd |=> rdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("rdata not idle zero");
	property p_window; rd && !inwin |=> rdata == 32'h0; endproperty
	a_window: assert property (p_window) else $error("outside read not zero");
	property p_resv;
		rd && inwin && (off == 12'h118 || off == 12'h11c || off == 12'h13c || off == 12'h120 || off == 12'h140)
		|=> rdata == 32'h0;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved read not zero");
	property p_handler; wr && inwin && off[11:7] == 5'h1 ##1 rd && addr == $past(addr) |=> rdata == $past(wdata, 2); endproperty
	a_handler: assert property (p_handler) else $error("handler readback");
	property p_mode; wr && inwin && off[11:7] == 5'h0 ##1 rd && addr == $past(addr) |=> rdata == ($past(wdata, 2) & 32'h7f); endproperty
	a_mode: assert property (p_mode) else $error("mode readback");
	property p_enabled; rd && inwin && off == 12'h110 |=> rdata == $past(s_q.en); endproperty
	a_enabled: assert property (p_enabled) else $error("enabled flags");
	property p_fast; rd && inwin && off == 12'h148 |=> rdata == $past(s_q.ff); endproperty
	a_fast: assert property (p_fast) else $error("fast redirect state");
	property p_spu; rd && inwin && off == 12'h134 |=> rdata == $past(s_q.spu); endproperty
	a_spu: assert property (p_spu) else $error("spurious readback");
	property p_spurious; rd && inwin && off == 12'h100 && s_q.en == 32'h0 |=> rdata == $past(s_q.spu); endproperty
	a_spurious: assert property (p_spurious) else $error("vector not spurious");
endmodule
bind vectored_irq_controller irq_ctrl_checker u_chk (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
	.rd(rd), .rdata(rdata));

// ### irq_source_model.sv
// Purpose: peripheral source lines feeding the controller
// Assumes: lines change just after a rising edge
// Notes: no reset, so a pin level is seen during reset
`timescale 1ns/1ps
module irq_source_model (
	input wire logic clk,
	input wire logic [31:0] want,
	output logic [31:0] src_in
);
	always_ff @(posedge clk) begin
		src_in <= want;
	end
endmodule

// ### vectored_irq_controller_tb_top.sv
// Purpose: register-level test of the interrupt controller
// Assumes: read data one cycle after the read strobe
// Notes: source lines come from the source model
`timescale 1ns/1ps
module vectored_irq_controller_tb_top;
	localparam logic [31:0] base = irq_ctrl_pkg::WINDOW_BASE;
	localparam logic [31:0] spu = 32'h0000_0f0f;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [31:0] addr = 32'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] want = 32'h2;
	logic [31:0] src_in;
	logic [31:0] rdata;
	logic irq_line;
	logic fiq_line;
	logic int_out;
	int miscompares = 0;
	int comparisons = 0;
	logic [11:0] offs [17] = '{12'h0, 12'h7c, 12'h80, 12'hfc, 12'h104, 12'h108, 12'h110, 12'h114, 12'h134,
		12'h138, 12'h148, 12'h118, 12'h11c, 12'h13c, 12'h120, 12'h130, 12'h140};
	always #2.5 clk = ~clk;
	irq_source_model src (.clk(clk), .want(want), .src_in(src_in));
	vectored_irq_controller dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .src_in(src_in), .irq_line(irq_line), .fiq_line(fiq_line), .int_out(int_out));
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t data %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t line %b exp %b", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_reg(input logic [31:0] a, input logic [31:0] exp);
		addr <= a;
		rd <= 1'b1;
		wr <= 1'b0;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk32(rdata, exp);
		@(posedge clk);
	endtask
	task automatic idle(input int n);
		wr <= 1'b0;
		rd <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
	task automatic wait_irq;
		idle(1);
		for (int i = 0; i < 20 && irq_line !== 1'b1; i++) @(posedge clk);
		chk1(irq_line, 1'b1);
	endtask
	task automatic finish_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge clk);
		miscompares++;
		finish_test();
	end
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		rd_reg(base + 32'h10c, 32'h2);
		want <= 32'h0;
		foreach (offs[i]) begin
			rd_reg(base + {20'h0, offs[i]}, 32'h0);
		end
		rd_reg(32'h0000_0100, 32'h0);
		wr_reg(base + 32'h110, 32'hffff_ffff);
		rd_reg(base + 32'h110, 32'h0);
		wr_reg(base + 32'hfc, 32'h8000_0001);
		rd_reg(base + 32'hfc, 32'h8000_0001);
		wr_reg(base + 32'h7c, 32'hffff_ffff);
		rd_reg(base + 32'h7c, 32'h7f);
		wr_reg(base + 32'h140, 32'h300);
		wr_reg(base + 32'h144, 32'h100);
		rd_reg(base + 32'h148, 32'h200);
		wr_reg(base + 32'h134, spu);
		wr_reg(base + 32'h150, 32'h7);
		wr_reg(base + 32'h154, 32'h4);
		rd_reg(base + 32'h100, spu);
		idle(3);
		chk1(int_out, 1'b1);
		wr_reg(base + 32'h150, 32'h4);
		idle(3);
		chk1(int_out, 1'b0);
		wr_reg(base + 32'h18, 32'h20);
		wr_reg(base + 32'h12c, 32'h40);
		rd_reg(base + 32'h10c, 32'h40);
		wr_reg(base + 32'h128, 32'h40);
		rd_reg(base + 32'h10c, 32'h0);
		wr_reg(base + 32'h120, 32'hf0);
		wr_reg(base + 32'h124, 32'hc0);
		rd_reg(base + 32'h110, 32'h30);
		wr_reg(base + 32'h10, 32'h3);
		wr_reg(base + 32'h14, 32'h6);
		wr_reg(base + 32'h90, 32'h0000_4444);
		wr_reg(base + 32'h94, 32'h0000_5555);
		wr_reg(base + 32'h138, 32'h1);
		want <= 32'h30;
		wait_irq();
		rd_reg(base + 32'h100, 32'h5555);
		rd_reg(base + 32'h108, 32'h0);
		wr_reg(base + 32'h100, 32'h0);
		rd_reg(base + 32'h108, 32'h5);
		wr_reg(base + 32'h138, 32'h0);
		want <= 32'h10;
		idle(3);
		wr_reg(base + 32'h130, 32'h1234_5678);
		wait_irq();
		rd_reg(base + 32'h100, 32'h4444);
		rd_reg(base + 32'h108, 32'h4);
		wr_reg(base + 32'h130, 32'h0);
		want <= 32'h0;
		idle(2);
		wr_reg(base + 32'h80, 32'h0000_6666);
		wr_reg(base + 32'h120, 32'h200);
		want <= 32'h200;
		idle(4);
		chk1(fiq_line, 1'b1);
		rd_reg(base + 32'h104, 32'h6666);
		wr_reg(base + 32'h138, 32'h2);
		idle(3);
		chk1(fiq_line, 1'b0);
		finish_test();
	end
endmodule
